/* testbench.sv */
/* Self-checking bench for the on-off controller and its load.
   Assumes the 12-bit default build and a 20 MHz clock. */
`timescale 1ns/1ps
module testbench;
  logic clk = 0, rst = 1, tu = 0, su = 0, sd = 0, ld = 0, sel = 0, em = 0, lo = 0, en = 1;
  logic [11:0] t = 12'h000, lv = 12'h064;
  wire [11:0] s1, s2;
  wire o1, o2;
  wire [1:0] rd, bi, ai, pw;
  int fail_count = 0, checked = 0, cyc = 0;
  always #25 clk = ~clk;
  tpc_onoff_ctrl u_tpc_onoff_ctrl (.clk(clk), .rst(rst), .ce(en), .temp_update(tu),
    .indicated_temp(t), .sel_second(sel), .step_up(su), .step_down(sd), .load_en(ld),
    .load_off(1'b0), .load_value(lv), .ext_mode(em), .ext_valid(1'b0), .ext_loop_open(lo),
    .external_first_setpoint(lv), .first_setpoint(s1), .second_setpoint(s2),
    .first_off(o1), .second_off(o2), .relay_drive(rd), .below_ind(bi), .above_ind(ai));
  tpc_load u_tpc_load (.relay_drive(rd), .load_power(pw));
  task chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task tally_and_finish;
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Code 1 steps up, 2 steps down, 4 loads lv into the selected channel.
  task strobe(input logic [2:0] k);
    @(negedge clk) {ld, sd, su} = k;
    @(negedge clk) {ld, sd, su} = 3'h0;
  endtask
  task tmp(input logic [11:0] v, input logic [1:0] e);
    @(negedge clk) begin
      tu = 1;
      t = v;
    end
    @(negedge clk) tu = 0;
    chk("power", {10'h000, e}, {10'h000, pw});
  endtask
  task sc_band;
    strobe(3'h4);
    tmp(12'h063, 2'h1);
    tmp(12'h064, 2'h1);
    tmp(12'h065, 2'h0);
    chk("ind", 12'h002, {10'h000, ai[0], bi[0]});
    tmp(12'h064, 2'h0);
    tmp(12'h063, 2'h1);
  endtask
  task sc_ch2;
    sel = 1;
    strobe(3'h1);
    strobe(3'h1);
    chk("sp2", 12'h001, s2);
    tmp(12'h000, 2'h3);
    strobe(3'h2);
    strobe(3'h2);
    chk("off2", 12'h001, {11'h000, o2});
    @(negedge clk);
    chk("power", 12'h001, {10'h000, pw});
  endtask
  task sc_span;
    sel = 1;
    lv = 12'hFFF;
    strobe(3'h4);
    chk("sp2", 12'h230, s2);
    strobe(3'h1);
    chk("sp2", 12'h230, s2);
    tmp(12'h22E, 2'h2);
    chk("ind2", 12'h001, {10'h000, ai[1], bi[1]});
    @(negedge clk) t = 12'h000;
    @(negedge clk);
    chk("power", 12'h002, {10'h000, pw});
    en = 0;
    tmp(12'h300, 2'h2);
    en = 1;
  endtask
  task sc_ext;
    sel = 0;
    em = 1;
    strobe(3'h1);
    chk("sp1", 12'h064, s1);
    tmp(12'h300, 2'h1);
    lo = 1;
    repeat (2) @(negedge clk);
    chk("above", 12'h001, {11'h000, ai[0]});
    chk("power", 12'h000, {10'h000, pw});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 400) begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 0;
    chk("offs", 12'h003, {10'h000, o2, o1});
    sc_band;
    sc_ch2;
    sc_span;
    sc_ext;
    @(negedge clk) begin
      rst = 1;
      em = 0;
      lo = 0;
    end
    @(negedge clk) rst = 0;
    chk("offs", 12'h003, {10'h000, o2, o1});
    chk("power", 12'h000, {10'h000, pw});
    chk("sp1", 12'h000, s1);
    tally_and_finish;
  end
endmodule // testbench

/* tpc_load.sv */
/* Far-side load behind both relays, powered only while its relay is energized.
   Assumes relay_drive is high for an energized relay. */
`timescale 1ns/1ps
module tpc_load (
  input wire [1:0] relay_drive,
  output wire [1:0] load_power
);
  // A released relay leaves the load unpowered, so a dead controller is safe.
  assign load_power = relay_drive;
endmodule // tpc_load

/* tpc_onoff_ctrl.v */
/*
  Two-point on-off temperature controller: two hysteresis channels, each
  with its own set point, off setting, relay drive and above/below flags.
  Assumes the filtered temperature arrives with a one-cycle update strobe
  and that all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`include "tpc_regs.vh"
// Operation
// - Two independent channels, own set point, relay.
// - Energized relay drops at set point plus one.
// - Released relay energizes at set point minus one.
// - Two degree band; inside it state holds.
// - Powered and cool: relay held energized.
// - Energize only by active drive, low side.
// - Power loss or reset releases every relay.
// - Open external loop forces channel one over-temperature.
// - Set point spans instrument range plus off.
// - Step below minimum gives off; up restores minimum.
// - Below and above indicators per channel.
// - External source drives only channel one.
module tpc_onoff_ctrl #(
  parameter TW = `TPC_TEMP_W,
  parameter [TW-1:0] SPAN_MIN = `TPC_SPAN_MIN,
  parameter [TW-1:0] SPAN_MAX = `TPC_SPAN_MAX
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire temp_update,
  input wire [TW-1:0] indicated_temp,
  input wire sel_second,
  input wire step_up,
  input wire step_down,
  input wire load_en,
  input wire load_off,
  input wire [TW-1:0] load_value,
  input wire ext_mode,
  input wire ext_valid,
  input wire ext_loop_open,
  input wire [TW-1:0] external_first_setpoint,
  output reg [TW-1:0] first_setpoint,
  output reg [TW-1:0] second_setpoint,
  output reg first_off,
  output reg second_off,
  output reg [1:0] relay_drive,
  output reg [1:0] below_ind,
  output reg [1:0] above_ind
);
  localparam [TW-1:0] HYST = `TPC_HYST;

  reg [TW-1:0] sp1_eff;
  reg off1_eff;
  reg force_over1;

  // Channel one follows the external source while that mode is chosen.
  always @* begin
    sp1_eff = first_setpoint;
    off1_eff = first_off;
    force_over1 = 1'b0;
    if (ext_mode) begin
      sp1_eff = external_first_setpoint;
      off1_eff = 1'b0;
      force_over1 = ext_loop_open;
    end
  end

  // Manual or serial set-point adjustment of the selected channel.
  reg [TW-1:0] sp1_nxt;
  reg [TW-1:0] sp2_nxt;
  reg off1_nxt;
  reg off2_nxt;
  wire [TW-1:0] load_clamped = (load_value > SPAN_MAX) ? SPAN_MAX : load_value;
  wire [TW-1:0] step_one = {{(TW-1){1'b0}}, 1'b1};
  wire step_dn_only = step_down && !step_up;
  wire step_up_only = step_up && !step_down;
  wire adj1 = !sel_second && !ext_mode;
  wire adj2 = sel_second;

  // A load outranks a step in the same cycle, so a serial command is never
  // nudged by a key that happens to be held at the same time.
  always @* begin
    sp1_nxt = first_setpoint;
    off1_nxt = first_off;
    if (adj1 && load_en) begin
      off1_nxt = load_off;
      if (!load_off)
        sp1_nxt = load_clamped;
    end else if (adj1 && step_dn_only) begin
      if (first_setpoint == SPAN_MIN)
        off1_nxt = 1'b1;
      else if (!first_off)
        sp1_nxt = first_setpoint - step_one;
    end else if (adj1 && step_up_only) begin
      if (first_off) begin
        off1_nxt = 1'b0;
        sp1_nxt = SPAN_MIN;
      end else if (first_setpoint < SPAN_MAX)
        sp1_nxt = first_setpoint + step_one;
    end
  end

  // Channel two has no external source and follows only local commands.
  always @* begin
    sp2_nxt = second_setpoint;
    off2_nxt = second_off;
    if (adj2 && load_en) begin
      off2_nxt = load_off;
      if (!load_off)
        sp2_nxt = load_clamped;
    end else if (adj2 && step_dn_only) begin
      if (second_setpoint == SPAN_MIN)
        off2_nxt = 1'b1;
      else if (!second_off)
        sp2_nxt = second_setpoint - step_one;
    end else if (adj2 && step_up_only) begin
      if (second_off) begin
        off2_nxt = 1'b0;
        sp2_nxt = SPAN_MIN;
      end else if (second_setpoint < SPAN_MAX)
        sp2_nxt = second_setpoint + step_one;
    end
  end

  // Both set points come up switched off, so no relay acts before setup unless external mode drives channel one.
  always @(posedge clk) begin
    if (rst) begin
      first_setpoint <= SPAN_MIN;
      second_setpoint <= SPAN_MIN;
      first_off <= `TPC_SP_RESET_OFF;
      second_off <= `TPC_SP_RESET_OFF;
    end else if (ce) begin
      first_setpoint <= sp1_nxt;
      second_setpoint <= sp2_nxt;
      first_off <= off1_nxt;
      second_off <= off2_nxt;
    end
  end

  // Thresholds are widened by one bit so set points at the span ends
  // do not wrap when the hysteresis is added to the set point or to the temperature.
  wire [TW:0] t_w = {1'b0, indicated_temp};
  wire [TW:0] hi1 = {1'b0, sp1_eff} + {1'b0, HYST};
  wire [TW:0] hi2 = {1'b0, second_setpoint} + {1'b0, HYST};
  wire [TW:0] lo1 = {1'b0, sp1_eff};
  wire [TW:0] lo2 = {1'b0, second_setpoint};
  wire [TW:0] t_plus = t_w + {1'b0, HYST};

  reg relay1_nxt;
  reg relay2_nxt;
  reg below1_nxt;
  reg below2_nxt;
  reg above1_nxt;
  reg above2_nxt;

  // Channel one. The open external loop outranks everything, then the
  // off setting, then the measurement, so a stale sample can never pull
  // a released relay back in.
  always @* begin
    relay1_nxt = relay_drive[0];
    below1_nxt = below_ind[0];
    above1_nxt = above_ind[0];
    if (force_over1) begin
      relay1_nxt = 1'b0;
      above1_nxt = 1'b1;
      below1_nxt = 1'b0;
    end else begin
      if (off1_eff)
        relay1_nxt = 1'b0;
      if (temp_update) begin
        below1_nxt = (t_w < lo1);
        above1_nxt = (t_w > lo1);
        if (!off1_eff) begin
          if (relay_drive[0] && t_w >= hi1)
            relay1_nxt = 1'b0;
          else if (!relay_drive[0] && t_plus <= lo1)
            relay1_nxt = 1'b1;
        end
      end
    end
  end

  // Channel two has the same band but no forced over-temperature.
  always @* begin
    relay2_nxt = relay_drive[1];
    below2_nxt = below_ind[1];
    above2_nxt = above_ind[1];
    if (second_off)
      relay2_nxt = 1'b0;
    if (temp_update) begin
      below2_nxt = (t_w < lo2);
      above2_nxt = (t_w > lo2);
      if (!second_off) begin
        if (relay_drive[1] && t_w >= hi2)
          relay2_nxt = 1'b0;
        else if (!relay_drive[1] && t_plus <= lo2)
          relay2_nxt = 1'b1;
      end
    end
  end

  // Relays start released; a channel energizes only once a measurement
  // shows it cool, so an unfiltered start-up value cannot pull a relay in.
  // A clock-enable low holds every output exactly where it stands.
  always @(posedge clk) begin
    if (rst) begin
      relay_drive <= 2'b00;
      below_ind <= 2'b00;
      above_ind <= 2'b00;
    end else if (ce) begin
      relay_drive <= {relay2_nxt, relay1_nxt};
      below_ind <= {below2_nxt, below1_nxt};
      above_ind <= {above2_nxt, above1_nxt};
    end
  end
endmodule // tpc_onoff_ctrl

/* tpc_properties.sv */
/* Port checker for the on-off controller.
   Assumes one clk domain with synchronous active-high rst. */
`timescale 1ns/1ps
module tpc_props (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire temp_update,
  input wire [11:0] indicated_temp,
  input wire ext_loop_open,
  input wire ext_mode,
  input wire [11:0] external_first_setpoint,
  input wire [11:0] first_setpoint,
  input wire first_off,
  input wire second_off,
  input wire [1:0] relay_drive,
  input wire [1:0] below_ind,
  input wire [1:0] above_ind
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire [11:0] sp1 = ext_mode ? external_first_setpoint : first_setpoint;
  wire open1 = ext_mode && ext_loop_open;
  wire q = ce && temp_update && !open1 && (ext_mode || !first_off);
  property p_hi; q && indicated_temp > sp1 |=> !relay_drive[0]; endproperty
  a_hi: assert property (p_hi) else $error("relay held above band");
  property p_lo; q && indicated_temp < sp1 |=> relay_drive[0]; endproperty
  a_lo: assert property (p_lo) else $error("relay not energized");
  property p_hold; q && indicated_temp == sp1 |=> $stable(relay_drive[0]); endproperty
  a_hold: assert property (p_hold) else $error("relay moved in band");
  property p_ind; q && indicated_temp > sp1 |=> above_ind[0] && !below_ind[0]; endproperty
  a_ind: assert property (p_ind) else $error("indicators wrong");
  property p_off; ce && second_off |=> !relay_drive[1]; endproperty
  a_off: assert property (p_off) else $error("relay on while off");
  property p_open; ce && open1 |=> !relay_drive[0] && above_ind[0]; endproperty
  a_open: assert property (p_open) else $error("open loop not over");
  property p_rst; disable iff (1'b0) rst |=> relay_drive == 2'h0 && first_off && second_off; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_low; $rose(relay_drive[0]) |-> $past(q && indicated_temp < sp1); endproperty
  a_low: assert property (p_low) else $error("energized without cool sample");
  c_on: cover property ($rose(relay_drive[0]));
  c_drop: cover property ($fell(relay_drive[0]));
  c_open: cover property (ext_loop_open && above_ind[0]);
endmodule // tpc_props
bind tpc_onoff_ctrl tpc_props u_tpc_props (.*);

/* tpc_regs.vh */
/*
  Constants for the two-point on-off controller: set-point encoding,
  hysteresis, span and reset off setting.
  Assumes temperatures are unsigned whole degrees in the active units.
*/
`ifndef TPC_REGS_VH
`define TPC_REGS_VH
`define TPC_TEMP_W 12
`define TPC_SPAN_MAX 12'h230
`define TPC_SPAN_MIN 12'h000
`define TPC_HYST 12'h001
`define TPC_SP_RESET_OFF 1'b1
`endif
